// file: rtl/sec_top.sv
/*
 * management-mode entry and exit control: request latch and priority,
 * store drain, acknowledge, context save, entry register values, resume
 * checks, restart slots, base relocation and shutdown.
 * assumes the core presents decoded opcodes at instruction boundaries,
 * supplies context words by save index and hands back reloaded slots.
 */
`timescale 1ns/1ns
`include "sec_regs.svh"

module sec_top (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_smm_request,
    input wire logic i_insn_boundary,
    input wire logic i_opcode_valid,
    input wire logic [7:0] i_opcode_byte0,
    input wire logic [7:0] i_opcode_byte1,
    input wire logic i_store_pending,
    input wire logic i_cycle_ready,
    input wire logic i_burst_ready,
    input wire logic i_hold,
    input wire logic i_address_float_request,
    input wire logic i_bus_backoff,
    input wire logic i_debug_pending,
    input wire logic i_ext_int_pending,
    input wire logic i_halted,
    input wire logic i_io_trapped,
    input wire logic i_nmi,
    input wire logic [31:0] i_save_data,
    input wire logic [31:0] i_ctrl0,
    input wire logic i_restore_valid,
    input wire logic [31:0] i_rst_dump_base,
    input wire logic [31:0] i_rst_ctrl0,
    input wire logic i_rst_halt_restart,
    input wire logic [7:0] i_rst_io_restart,
    input wire logic i_seg_load,
    input wire logic [15:0] i_seg_selector,
    output logic o_smm_active_ack_n,
    output logic o_in_smm,
    output logic o_invalid_opcode,
    output logic o_shutdown,
    output logic o_shutdown_cycle,
    output logic o_events_held,
    output logic o_mem_wr,
    output logic [31:0] o_mem_addr,
    output logic [31:0] o_mem_data,
    output logic [2:0] o_save_index,
    output logic o_load_entry,
    output logic [31:0] o_flags,
    output logic [31:0] o_debug_ctrl,
    output logic [31:0] o_ip,
    output logic [31:0] o_ctrl0,
    output logic [15:0] o_cs_sel,
    output logic [31:0] o_cs_base,
    output logic [31:0] o_seg_base,
    output logic o_int_block,
    output logic [31:0] o_smm_base,
    output logic o_resume_done,
    output logic o_restart_halt,
    output logic o_restart_io
);

    sec_pkg::sec_state_type state, next_state; // controller state
    logic pending, next_pending; // one latched request
    logic halt_at_entry, next_halt_at_entry; // request interrupted a halt
    logic io_at_entry, next_io_at_entry; // request came from an io access
    logic next_in_smm, next_ack_n, next_inv, next_shut, next_shut_cyc;
    logic next_held, next_mem_wr, next_load, next_int_block, next_done;
    logic next_rhalt, next_rio;
    logic [2:0] next_idx;
    logic [31:0] next_addr, next_data, next_flags, next_dbg, next_ip;
    logic [31:0] next_ctrl0, next_cs_base, next_seg_base, next_base;
    logic [15:0] next_cs_sel;
    logic is_resume; // resume opcode at this boundary
    logic fault; // reloaded state invalid
    logic req_seen; // a request is live or latched
    logic bus_free; // no arbitration input holds the bus
    logic wr_done; // current save write acknowledged

    // slot offset of each saved item, used for first and later writes
    function automatic logic [31:0] slot_ofs(input logic [2:0] idx);
        logic [31:0] ofs;
        ofs = `SEC_SLOT_CTRL0;
        case (idx)
            3'h1: ofs = `SEC_SLOT_FLAGS;
            3'h2: ofs = `SEC_SLOT_IP;
            3'h3: ofs = `SEC_SLOT_HALT;
            3'h4: ofs = `SEC_SLOT_IO;
            3'h5: ofs = `SEC_SLOT_DUMP;
            default: ofs = `SEC_SLOT_CTRL0;
        endcase
        return ofs;
    endfunction : slot_ofs

    // word saved for an index; halt and io slots are built here
    function automatic logic [31:0] save_word(input logic [2:0] idx, input logic halted,
                                              input logic [31:0] core, input logic [31:0] base);
        logic [31:0] w;
        w = core;
        if (idx == `SEC_IDX_HALT) begin
            w = {31'h0, halted};
        end else if (idx == `SEC_IDX_IO) begin
            w = `SEC_ZERO32;
        end else if (idx == `SEC_IDX_DUMP) begin
            w = base;
        end
        return w;
    endfunction : save_word

    sec_opcode_decode u_decode (
        .i_valid(i_opcode_valid),
        .i_byte0(i_opcode_byte0),
        .i_byte1(i_opcode_byte1),
        .o_is_resume(is_resume)
    );

    sec_resume_check u_check (
        .i_dump_base(i_rst_dump_base),
        .i_ctrl0(i_rst_ctrl0),
        .o_fault(fault)
    );

    // bus status terms
    always_comb begin
        bus_free = !i_hold && !i_address_float_request && !i_bus_backoff;
        wr_done = o_mem_wr && (i_cycle_ready || i_burst_ready) && bus_free;
        req_seen = i_smm_request || pending;
    end

    // next values of the whole controller
    always_comb begin
        next_state = state;
        next_pending = pending;
        next_halt_at_entry = halt_at_entry;
        next_io_at_entry = io_at_entry;
        next_in_smm = o_in_smm;
        next_ack_n = o_smm_active_ack_n;
        next_inv = 1'b0;
        next_shut = o_shutdown;
        next_shut_cyc = 1'b0;
        next_held = 1'b0;
        next_mem_wr = o_mem_wr;
        next_idx = o_save_index;
        next_addr = o_mem_addr;
        next_data = o_mem_data;
        next_load = 1'b0;
        next_flags = o_flags;
        next_dbg = o_debug_ctrl;
        next_ip = o_ip;
        next_ctrl0 = o_ctrl0;
        next_cs_sel = o_cs_sel;
        next_cs_base = o_cs_base;
        next_seg_base = o_seg_base;
        next_int_block = o_int_block;
        next_base = o_smm_base;
        next_done = 1'b0;
        next_rhalt = o_restart_halt;
        next_rio = o_restart_io;
        // a request outside idle boundaries is kept; set and take never fall in one cycle
        if (i_smm_request && !(state == sec_pkg::ST_IDLE && i_insn_boundary)) begin
            next_pending = 1'b1;
        end
        // selector loads inside the mode use real-address bases
        if (o_in_smm && i_seg_load) begin
            next_seg_base = {12'h000, i_seg_selector, 4'h0};
        end
        unique case (state)
            sec_pkg::ST_IDLE: begin
                if (i_insn_boundary && req_seen) begin
                    // request outranks debug traps and interrupts
                    next_held = i_debug_pending || i_ext_int_pending;
                    next_pending = 1'b0;
                    next_halt_at_entry = i_halted;
                    next_io_at_entry = i_io_trapped;
                    next_rhalt = 1'b0;
                    next_rio = 1'b0;
                    next_state = sec_pkg::ST_DRAIN;
                end else if (i_insn_boundary && is_resume) begin
                    next_inv = 1'b1;
                end
            end
            sec_pkg::ST_DRAIN: begin
                // wait until the write buffers are empty
                if (!i_store_pending) begin
                    next_ack_n = 1'b0;
                    next_idx = 3'h0;
                    next_addr = o_smm_base + `SEC_SAVE_OFS + slot_ofs(3'h0);
                    next_data = save_word(3'h0, halt_at_entry, i_save_data, o_smm_base);
                    next_mem_wr = 1'b1;
                    next_state = sec_pkg::ST_SAVE;
                end
            end
            sec_pkg::ST_SAVE: begin
                // a write is only done when the bus is ours and ready
                if (wr_done) begin
                    if (o_save_index == `SEC_SLOT_COUNT - 3'h1) begin
                        next_mem_wr = 1'b0;
                        next_load = 1'b1;
                        next_in_smm = 1'b1;
                        next_flags = `SEC_FLAGS_INIT;
                        next_dbg = `SEC_DEBUG_INIT;
                        next_ip = `SEC_IP_INIT;
                        next_ctrl0 = i_ctrl0;
                        next_ctrl0[`SEC_PROT_BIT] = 1'b0;
                        next_ctrl0[`SEC_COPRO_BIT] = 1'b0;
                        next_ctrl0[`SEC_FPU_SW_BIT] = 1'b0;
                        next_ctrl0[`SEC_PAGING_BIT] = 1'b0;
                        // selector is fixed even if the base was moved
                        next_cs_sel = `SEC_CS_SEL_INIT;
                        next_cs_base = o_smm_base;
                        next_seg_base = `SEC_ZERO32;
                        next_int_block = 1'b1;
                        next_state = sec_pkg::ST_HANDLER;
                    end else begin
                        next_idx = o_save_index + 3'h1;
                        next_addr = o_smm_base + `SEC_SAVE_OFS + slot_ofs(next_idx);
                        next_data = save_word(next_idx, halt_at_entry, i_save_data, o_smm_base);
                    end
                end
            end
            sec_pkg::ST_HANDLER: begin
                // resume is legal here; further requests only latch
                if (i_insn_boundary && is_resume) begin
                    next_state = sec_pkg::ST_RESTORE;
                end
            end
            sec_pkg::ST_RESTORE: begin
                if (i_restore_valid && fault) begin
                    next_shut = 1'b1;
                    next_shut_cyc = 1'b1;
                    next_state = sec_pkg::ST_SHUTDOWN;
                end else if (i_restore_valid) begin
                    next_base = i_rst_dump_base;
                    next_rhalt = halt_at_entry && i_rst_halt_restart;
                    next_rio = io_at_entry && (i_rst_io_restart == `SEC_IO_RESTART_ON);
                    next_ack_n = 1'b1;
                    next_in_smm = 1'b0;
                    next_int_block = 1'b0;
                    next_done = 1'b1;
                    next_state = sec_pkg::ST_IDLE;
                end
            end
            sec_pkg::ST_SHUTDOWN: begin
                // only an nmi wakes it; the mode is abandoned
                if (i_nmi) begin
                    next_shut = 1'b0;
                    next_ack_n = 1'b1;
                    next_in_smm = 1'b0;
                    next_int_block = 1'b0;
                    next_state = sec_pkg::ST_IDLE;
                end
            end
            default: begin
                next_state = sec_pkg::ST_IDLE;
            end
        endcase
    end

    // register stage; reset leaves the mode at once
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state <= sec_pkg::ST_IDLE;
            pending <= 1'b0;
            halt_at_entry <= 1'b0;
            io_at_entry <= 1'b0;
            o_in_smm <= 1'b0;
            o_smm_active_ack_n <= 1'b1;
            o_invalid_opcode <= 1'b0;
            o_shutdown <= 1'b0;
            o_shutdown_cycle <= 1'b0;
            o_events_held <= 1'b0;
            o_mem_wr <= 1'b0;
            o_save_index <= 3'h0;
            o_mem_addr <= `SEC_ZERO32;
            o_mem_data <= `SEC_ZERO32;
            o_load_entry <= 1'b0;
            o_flags <= `SEC_ZERO32;
            o_debug_ctrl <= `SEC_ZERO32;
            o_ip <= `SEC_ZERO32;
            o_ctrl0 <= `SEC_ZERO32;
            o_cs_sel <= 16'h0000;
            o_cs_base <= `SEC_ZERO32;
            o_seg_base <= `SEC_ZERO32;
            o_int_block <= 1'b0;
            o_smm_base <= `SEC_BASE_INIT;
            o_resume_done <= 1'b0;
            o_restart_halt <= 1'b0;
            o_restart_io <= 1'b0;
        end else begin
            state <= next_state;
            pending <= next_pending;
            halt_at_entry <= next_halt_at_entry;
            io_at_entry <= next_io_at_entry;
            o_in_smm <= next_in_smm;
            o_smm_active_ack_n <= next_ack_n;
            o_invalid_opcode <= next_inv;
            o_shutdown <= next_shut;
            o_shutdown_cycle <= next_shut_cyc;
            o_events_held <= next_held;
            o_mem_wr <= next_mem_wr;
            o_save_index <= next_idx;
            o_mem_addr <= next_addr;
            o_mem_data <= next_data;
            o_load_entry <= next_load;
            o_flags <= next_flags;
            o_debug_ctrl <= next_dbg;
            o_ip <= next_ip;
            o_ctrl0 <= next_ctrl0;
            o_cs_sel <= next_cs_sel;
            o_cs_base <= next_cs_base;
            o_seg_base <= next_seg_base;
            o_int_block <= next_int_block;
            o_smm_base <= next_base;
            o_resume_done <= next_done;
            o_restart_halt <= next_rhalt;
            o_restart_io <= next_rio;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    a_resume_outside: assert property (
        (state == sec_pkg::ST_IDLE && i_insn_boundary && is_resume && !req_seen) |=> o_invalid_opcode)
        else $error("resume outside mode did not raise invalid opcode");
    a_no_invalid_inside: assert property (
        o_invalid_opcode |-> !$past(o_in_smm))
        else $error("invalid opcode raised inside the mode");
    a_fault_shutdown: assert property (
        (state == sec_pkg::ST_RESTORE && i_restore_valid && fault) |=> o_shutdown && o_shutdown_cycle)
        else $error("bad reloaded state did not shut down");
    a_shutdown_stays: assert property (
        (o_shutdown && !i_nmi) |=> o_shutdown && !o_shutdown_cycle)
        else $error("shutdown left without nmi");
    a_drain_wait: assert property (
        (state == sec_pkg::ST_DRAIN && i_store_pending) |=> state == sec_pkg::ST_DRAIN && o_smm_active_ack_n)
        else $error("entry went on before stores drained");
    a_entry_values: assert property (
        $rose(o_load_entry) |-> o_flags == `SEC_FLAGS_INIT && o_debug_ctrl == `SEC_DEBUG_INIT
            && o_ip == `SEC_IP_INIT && o_cs_sel == `SEC_CS_SEL_INIT && !o_smm_active_ack_n)
        else $error("entry values wrong");
    a_ctrl_cleared: assert property (
        o_load_entry |-> !o_ctrl0[`SEC_PROT_BIT] && !o_ctrl0[`SEC_PAGING_BIT]
            && !o_ctrl0[`SEC_COPRO_BIT] && !o_ctrl0[`SEC_FPU_SW_BIT])
        else $error("control bits not cleared on entry");
    a_base_reload: assert property (
        (state == sec_pkg::ST_RESTORE && i_restore_valid && !fault) |=> o_smm_base == $past(i_rst_dump_base)
            && o_resume_done && o_smm_active_ack_n)
        else $error("base not reloaded on resume");
    a_save_addr: assert property (
        o_mem_wr |-> o_mem_addr == o_smm_base + `SEC_SAVE_OFS + slot_ofs(o_save_index))
        else $error("save write at wrong address");
    a_latch_request: assert property (
        (o_in_smm && i_smm_request) |=> pending ##0 state != sec_pkg::ST_DRAIN)
        else $error("request in mode not latched");

    c_entry: cover property ($rose(o_load_entry));
    c_resume: cover property (o_resume_done);
    c_shutdown: cover property (o_shutdown_cycle);
    c_pending_served: cover property (o_resume_done && pending ##[1:20] state == sec_pkg::ST_DRAIN);

endmodule : sec_top

// file: common/sec_regs.svh
/*
 * constants of the management-mode entry and exit control: opcode bytes,
 * entry values, control bit positions, save slot offsets.
 * assumes it is included by bare name from design files.
 */
`ifndef SEC_REGS_SVH
`define SEC_REGS_SVH

// resume instruction opcode bytes
`define SEC_RESUME_OP0 8'h0F
`define SEC_RESUME_OP1 8'hAA

// values loaded on entry, and the base loaded at reset
`define SEC_FLAGS_INIT 32'h0000_0002
`define SEC_DEBUG_INIT 32'h0000_0400
`define SEC_IP_INIT 32'h0000_8000
`define SEC_CS_SEL_INIT 16'h3000
`define SEC_BASE_INIT 32'h0003_0000
`define SEC_ZERO32 32'h0000_0000

// save area sits at base plus this offset plus the slot offset
`define SEC_SAVE_OFS 32'h0000_8000
// base must be 32-Kbyte aligned: these low bits must be zero
`define SEC_ALIGN_MASK 32'h0000_7FFF

// control register zero bit positions
`define SEC_PROT_BIT 0
`define SEC_COPRO_BIT 2
`define SEC_FPU_SW_BIT 3
`define SEC_WT_OFF_BIT 29
`define SEC_CACHE_OFF_BIT 30
`define SEC_PAGING_BIT 31

// save slot offsets, in save order
`define SEC_SLOT_CTRL0 32'h0000_7FFC
`define SEC_SLOT_FLAGS 32'h0000_7FF4
`define SEC_SLOT_IP 32'h0000_7FF0
`define SEC_SLOT_HALT 32'h0000_7F02
`define SEC_SLOT_IO 32'h0000_7F00
`define SEC_SLOT_DUMP 32'h0000_7EF8
`define SEC_SLOT_COUNT 3'h6
`define SEC_IDX_HALT 3'h3
`define SEC_IDX_IO 3'h4
`define SEC_IDX_DUMP 3'h5
`define SEC_IO_RESTART_ON 8'hFF

// real-address segment base shift
`define SEC_SEG_SHIFT 4

`endif

// file: common/sec_pkg.sv
/*
 * types of the management-mode entry and exit control.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package sec_pkg;

    // controller states, one-hot
    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_DRAIN = 6'b000010,
        ST_SAVE = 6'b000100,
        ST_HANDLER = 6'b001000,
        ST_RESTORE = 6'b010000,
        ST_SHUTDOWN = 6'b100000
    } sec_state_type;

endpackage : sec_pkg

// file: rtl/sec_opcode_decode.sv
/*
 * recognises the two-byte resume instruction among decoded opcodes.
 * assumes bytes are presented together with a valid qualifier.
 */
`timescale 1ns/1ns
`include "sec_regs.svh"

module sec_opcode_decode (
    input wire logic i_valid,
    input wire logic [7:0] i_byte0,
    input wire logic [7:0] i_byte1,
    output logic o_is_resume
);

    // both bytes must match; a lone first byte is any other extended opcode
    always_comb begin
        o_is_resume = i_valid && (i_byte0 == `SEC_RESUME_OP0) && (i_byte1 == `SEC_RESUME_OP1);
    end

endmodule : sec_opcode_decode

// file: rtl/sec_resume_check.sv
/*
 * validity check of state reloaded by the resume instruction.
 * assumes the reloaded dump base and control register are stable inputs.
 */
`timescale 1ns/1ns
`include "sec_regs.svh"

module sec_resume_check (
    input wire logic [31:0] i_dump_base,
    input wire logic [31:0] i_ctrl0,
    output logic o_fault
);

    logic misaligned; // base not on a 32-Kbyte boundary
    logic bad_ctrl; // illegal control bit combination

    // either failure sends the device to shutdown
    always_comb begin
        misaligned = (i_dump_base & `SEC_ALIGN_MASK) != `SEC_ZERO32;
        bad_ctrl = (i_ctrl0[`SEC_PAGING_BIT] && !i_ctrl0[`SEC_PROT_BIT])
            || (i_ctrl0[`SEC_WT_OFF_BIT] && !i_ctrl0[`SEC_CACHE_OFF_BIT]);
        o_fault = misaligned || bad_ctrl;
    end

endmodule : sec_resume_check

// file: tb/sec_chipset_model.sv
/*
 * chipset model: answers save writes and logs them by save index.
 * assumes one save write at a time, taken at a rising edge with ready.
 */
`timescale 1ns/1ns
module sec_chipset_model (
    input wire logic i_clk,
    input wire logic i_mem_wr,
    input wire logic [31:0] i_mem_addr,
    input wire logic [31:0] i_mem_data,
    input wire logic [2:0] i_save_index,
    output logic o_cycle_ready,
    output logic o_burst_ready,
    output logic [31:0] o_addr_log [6],
    output logic [31:0] o_data_log [6]
);
    int wait_cnt = 0; // edges the current write has waited
    // log a write when ready meets it
    always @(posedge i_clk) begin
        if (i_mem_wr && (o_cycle_ready || o_burst_ready)) begin
            o_addr_log[i_save_index] <= i_mem_addr;
            o_data_log[i_save_index] <= i_mem_data;
            wait_cnt <= 0;
        end else if (i_mem_wr) begin
            wait_cnt <= wait_cnt + 1;
        end
    end
    // odd slots answer at once, even slots stall so the slow path is used
    always @(negedge i_clk) begin
        o_cycle_ready <= i_mem_wr && i_save_index[0];
        o_burst_ready <= i_mem_wr && !i_save_index[0] && wait_cnt >= 2;
    end
endmodule : sec_chipset_model

// file: tb/sec_top_tb.sv
/*
 * testbench of the management-mode control: entry, resume, faults, reset.
 * assumes the chipset model answers every save write.
 */
`timescale 1ns/1ns
module sec_top_tb;
    logic i_clk = 1'b0, i_rstn = 1'b0, i_smm_request = 1'b0, i_insn_boundary = 1'b0, i_opcode_valid = 1'b0;
    logic i_store_pending = 1'b0, i_hold = 1'b0, i_address_float_request = 1'b0, i_bus_backoff = 1'b0;
    logic i_debug_pending = 1'b0, i_ext_int_pending = 1'b0, i_halted = 1'b0, i_io_trapped = 1'b0, i_nmi = 1'b0;
    logic i_restore_valid = 1'b0, i_rst_halt_restart = 1'b0, i_seg_load = 1'b0, i_cycle_ready, i_burst_ready;
    logic [7:0] i_opcode_byte0 = 8'h00, i_opcode_byte1 = 8'h00, i_rst_io_restart = 8'h00;
    logic [15:0] i_seg_selector = 16'h0000, o_cs_sel;
    logic [31:0] i_save_data, i_ctrl0 = 32'hFFFF_FFFF, i_rst_dump_base = 32'h0, i_rst_ctrl0 = 32'h0;
    logic o_smm_active_ack_n, o_in_smm, o_invalid_opcode, o_shutdown, o_shutdown_cycle, o_events_held, o_mem_wr;
    logic o_load_entry, o_int_block, o_resume_done, o_restart_halt, o_restart_io;
    logic [2:0] o_save_index;
    logic [31:0] o_mem_addr, o_mem_data, o_flags, o_debug_ctrl, o_ip, o_ctrl0, o_cs_base, o_seg_base, o_smm_base;
    logic [31:0] alog [6], dlog [6];
    logic [31:0] slot [6] = '{32'h7FFC, 32'h7FF4, 32'h7FF0, 32'h7F02, 32'h7F00, 32'h7EF8};
    int n_errors = 0, tests_run = 0;
    always #5 i_clk = ~i_clk;
    // core word tagged by the index that the controller latches next: it takes the data at the same edge that loads that index
    assign i_save_data = 32'hA5A5_0000 | {29'h0, o_mem_wr ? o_save_index + 3'h1 : 3'h0};
    sec_top u_dut (.*);
    sec_chipset_model u_chip (.i_clk(i_clk), .i_mem_wr(o_mem_wr), .i_mem_addr(o_mem_addr),
        .i_mem_data(o_mem_data), .i_save_index(o_save_index), .o_cycle_ready(i_cycle_ready),
        .o_burst_ready(i_burst_ready), .o_addr_log(alog), .o_data_log(dlog));
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic results();
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results
    // one boundary cycle carrying an opcode
    task automatic bnd(input logic [7:0] op0, input logic [7:0] op1);
        i_insn_boundary = 1'b1;
        i_opcode_valid = 1'b1;
        i_opcode_byte0 = op0;
        i_opcode_byte1 = op1;
        @(negedge i_clk);
        i_insn_boundary = 1'b0;
        i_opcode_valid = 1'b0;
    endtask : bnd
    // bounded wait: 0 entry loaded, 1 resume done, 2 shutdown
    task automatic wait_on(input int k);
        for (int i = 0; i < 40; i++) begin
            @(negedge i_clk);
            if ((k == 0 && o_load_entry === 1'b1) || (k == 1 && o_resume_done === 1'b1)) return;
            if (k == 2 && o_shutdown === 1'b1) return;
        end
        n_errors++;
        $display("ERROR wait %0d expected 1 seen 0", k);
        results();
    endtask : wait_on
    // entry with debug and interrupt pending and stores still draining
    task automatic enter(input logic [31:0] base, input logic hlt, input logic rq);
        i_halted = hlt;
        i_io_trapped = hlt;
        i_smm_request = rq;
        i_debug_pending = 1'b1;
        i_ext_int_pending = 1'b1;
        i_store_pending = 1'b1;
        bnd(8'h90, 8'h00);
        i_smm_request = 1'b0;
        i_debug_pending = 1'b0;
        i_ext_int_pending = 1'b0;
        chk("held", 1, o_events_held);
        repeat (3) begin
            @(negedge i_clk);
            chk("ack_drain", 1, o_smm_active_ack_n);
        end
        i_store_pending = 1'b0;
        i_bus_backoff = 1'b1; // save writes must stall while the bus is taken away
        repeat (6) @(negedge i_clk);
        chk("bus_held", 0, o_save_index);
        i_bus_backoff = 1'b0;
        wait_on(0);
        chk("ack", 0, o_smm_active_ack_n);
        chk("in_smm", 1, o_in_smm);
        chk("flags", 32'h0000_0002, o_flags);
        chk("dbg", 32'h0000_0400, o_debug_ctrl);
        chk("ip", 32'h0000_8000, o_ip);
        chk("ctrl0", 32'h7FFF_FFF2, o_ctrl0);
        chk("cs_sel", 32'h3000, o_cs_sel);
        chk("cs_base", base, o_cs_base);
        chk("seg_base", 0, o_seg_base);
        chk("int_blk", 1, o_int_block);
        for (int i = 0; i < 6; i++) begin
            chk("save_addr", base + 32'h8000 + slot[i], alog[i]);
            chk("save_data", i < 3 ? 32'hA5A5_0000 | i : i == 3 ? {31'h0, hlt} : i == 4 ? 0 : base,
                dlog[i]);
        end
    endtask : enter
    // resume with the given reloaded slots
    task automatic resume(input logic [31:0] dump, input logic [31:0] c0r, input logic hr, input logic [7:0] io);
        i_rst_dump_base = dump;
        i_rst_ctrl0 = c0r;
        i_rst_halt_restart = hr;
        i_rst_io_restart = io;
        i_restore_valid = 1'b1;
        bnd(8'h0F, 8'hAA);
        chk("no_invalid", 0, o_invalid_opcode);
    endtask : resume
    initial begin
        repeat (12) @(negedge i_clk);
        i_rstn = 1'b1;
        chk("rst_ack", 1, o_smm_active_ack_n);
        chk("rst_base", 32'h0003_0000, o_smm_base);
        bnd(8'h0F, 8'hAA);
        chk("invalid", 1, o_invalid_opcode);
        @(negedge i_clk);
        enter(32'h0003_0000, 1'b1, 1'b1);
        i_seg_load = 1'b1;
        i_seg_selector = 16'h1234;
        @(negedge i_clk);
        i_seg_load = 1'b0;
        i_smm_request = 1'b1;
        @(negedge i_clk);
        i_smm_request = 1'b0;
        chk("seg_load", 32'h0001_2340, o_seg_base);
        chk("ack_hold", 0, o_smm_active_ack_n);
        resume(32'h0004_0000, 32'h0000_0001, 1'b1, 8'hFF);
        wait_on(1);
        i_restore_valid = 1'b0;
        i_rst_dump_base = ~i_rst_dump_base; // slots no longer valid
        chk("ack_off", 1, o_smm_active_ack_n);
        chk("left", 0, o_in_smm);
        chk("base", 32'h0004_0000, o_smm_base);
        chk("rs_halt", 1, o_restart_halt);
        chk("rs_io", 1, o_restart_io);
        enter(32'h0004_0000, 1'b0, 1'b0);
        // misaligned dump base, paging without protection, write-through-off without cache-off
        for (int k = 0; k < 3; k++) begin
            resume(k == 0 ? 32'h0004_1000 : 32'h0004_0000, k == 1 ? 32'h8000_0000 :
                k == 2 ? 32'h2000_0001 : 32'h0000_0001, 0, 0);
            wait_on(2);
            chk("shut_cyc", 1, o_shutdown_cycle);
            i_restore_valid = 1'b0;
            repeat (3) @(negedge i_clk);
            chk("shut_stay", 1, o_shutdown);
            i_nmi = 1'b1;
            @(negedge i_clk);
            i_nmi = 1'b0;
            @(negedge i_clk);
            chk("shut_exit", 0, o_shutdown);
            enter(32'h0004_0000, 1'b0, 1'b1);
        end
        i_rstn = 1'b0;
        @(negedge i_clk);
        i_rstn = 1'b1;
        chk("rst_ack2", 1, o_smm_active_ack_n);
        chk("rst_mode", 0, o_in_smm);
        results();
    end
endmodule : sec_top_tb
